/* File: rtl/pif_defs.svh */
// offsets, field positions and reset values of the peripheral flag block
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef PIF_DEFS_SVH
`define PIF_DEFS_SVH

`define PIF_OFS_FLAGS_C  8'h00
`define PIF_OFS_FLAGS_D  8'h04
`define PIF_OFS_ENABLE_C 8'h08
`define PIF_OFS_ENABLE_D 8'h0C
`define PIF_OFS_STATUS   8'h10
`define PIF_OFS_MASK     8'h14

`define PIF_IMPL_C       8'h7A
`define PIF_IMPL_D       8'h33

`define PIF_BIT_CCP5     6
`define PIF_BIT_CCP4     5
`define PIF_BIT_CCP3     4
`define PIF_BIT_TIMER6   3
`define PIF_BIT_TIMER4   1
`define PIF_BIT_RX2      5
`define PIF_BIT_TX2      4
`define PIF_BIT_BCOL2    1
`define PIF_BIT_SYNC2    0

`define PIF_STAT_C       0
`define PIF_STAT_D       1

`define PIF_RST_REG8     8'h00
`define PIF_RST_STAT     2'h0
`define PIF_RST_DATA     32'h0000_0000
`define PIF_RESP_OK      2'h0
`define PIF_RESP_DECERR  2'h3

`endif

/* File: rtl/pif_pkg.sv */
// types shared by the peripheral flag block
// no assumptions beyond the defs header
package pif_pkg;
   typedef enum logic {
      PIF_IDLE,
      PIF_ACK
   } pif_bus_state_t;
endpackage

/* File: rtl/pif_flag_bank.sv */
// one flag register with its matching enable register
// assumes writes are single-cycle pulses from the bus front end
`timescale 1ns/1ps
`include "pif_defs.svh"
module pif_flag_bank #(
   parameter int           W    = 8,
   parameter logic [W-1:0] IMPL = '1
) (
   input  wire logic         mclk,       // system clock
   input  wire logic         srst,       // sync reset, high
   input  wire logic [W-1:0] event_in,   // event pulses
   input  wire logic         flag_wr,    // write flags
   input  wire logic         en_wr,      // write enables
   input  wire logic [W-1:0] wdata,      // write data
   output logic      [W-1:0] flags_ff,   // pending flags
   output logic      [W-1:0] enables_ff  // enable bits
);
   logic [W-1:0] nxt_flags;
   logic [W-1:0] nxt_enables;

   always_comb begin
      nxt_flags   = flags_ff;
      nxt_enables = enables_ff;
      if (flag_wr) begin
         nxt_flags = wdata;
      end
      // R7 set ignores enables
      nxt_flags = (nxt_flags | event_in) & IMPL;
      if (en_wr) begin
         nxt_enables = wdata & IMPL;
      end
   end

   // R9 clear on reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         flags_ff   <= W'(`PIF_RST_REG8);
         enables_ff <= W'(`PIF_RST_REG8);
      end else begin
         flags_ff   <= nxt_flags;
         enables_ff <= nxt_enables;
      end
   end
endmodule

/* File: rtl/pif_bus_front.sv */
// avalon-mm handshake: one wait cycle per transfer
// assumes the master holds its request until waitrequest is seen low
`timescale 1ns/1ps
module pif_bus_front (
   input  wire logic mclk,            // system clock
   input  wire logic srst,            // sync reset, high
   input  wire logic avs_read,        // read request
   input  wire logic avs_write,       // write request
   output logic      avs_waitrequest, // stall, from flop
   output logic      capture,         // latch read data
   output logic      commit_wr        // write takes effect
);
   pif_pkg::pif_bus_state_t state_ff;
   pif_pkg::pif_bus_state_t nxt_state;
   logic                    nxt_wait;

   always_comb begin
      nxt_state = state_ff;
      nxt_wait  = 1'b1;
      case (state_ff)
         pif_pkg::PIF_IDLE: begin
            if (avs_read || avs_write) begin
               nxt_state = pif_pkg::PIF_ACK;
               nxt_wait  = 1'b0;
            end
         end
         pif_pkg::PIF_ACK: begin
            nxt_state = pif_pkg::PIF_IDLE;
         end
         default: begin
            nxt_state = pif_pkg::PIF_IDLE;
         end
      endcase
   end

   assign capture   = (state_ff == pif_pkg::PIF_IDLE) && (avs_read || avs_write);
   assign commit_wr = (state_ff == pif_pkg::PIF_ACK) && avs_write;

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_ff        <= pif_pkg::PIF_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         state_ff        <= nxt_state;
         avs_waitrequest <= nxt_wait;
      end
   end
endmodule

/* File: rtl/pif_irq_regs.sv */
// peripheral interrupt flag block: two flag registers, two enable registers,
// an event status/mask pair and the interrupt outputs behind an avalon-mm port
// assumes event inputs are synchronous one-cycle (or longer) pulses on mclk
//
// Overview of operation
// R1: flag bit reads 1 while pending, 0 when not pending.
// R2: flag reg c holds capture/compare five, four, three at bits 6, 5, 4.
// R3: flag reg c bit 3 on sixth timer match, bit 1 on fourth.
// R4: flag reg c bits 7, 2 and 0 always read zero.
// R5: flag reg d bit 5 serial receive, bit 4 transmit; bits 7, 6, 3, 2 zero.
// R6: flag reg d bit 1 sync port collision, bit 0 sync port event.
// R7: flags set on their event regardless of any enable bit.
// R8: software should clear a flag before enabling its interrupt.
// R9: implemented flags read/write by software, cleared by every reset.
// R10: enable bit 1 lets its interrupt through, 0 blocks it.
// R11: request output is OR over all flags ANDed with enables.
`timescale 1ns/1ps
`include "pif_defs.svh"
module pif_irq_regs (
   input  wire logic        mclk,                   // system clock, 10 MHz
   input  wire logic        srst,                   // sync reset, high
   input  wire logic [7:0]  avs_address,            // byte address
   input  wire logic        avs_read,               // read strobe
   input  wire logic        avs_write,              // write strobe
   input  wire logic [31:0] avs_writedata,          // write data
   input  wire logic [3:0]  avs_byteenable,         // byte lanes
   output logic      [31:0] avs_readdata,           // read data, from flop
   output logic      [1:0]  avs_response,           // ok or decode error
   output logic             avs_waitrequest,        // stall, from flop
   input  wire logic        ev_capcomp_five,        // capture/compare 5 event
   input  wire logic        ev_capcomp_four,        // capture/compare 4 event
   input  wire logic        ev_capcomp_three,       // capture/compare 3 event
   input  wire logic        ev_sixth_timer_match,   // timer 6 period match
   input  wire logic        ev_fourth_timer_match,  // timer 4 period match
   input  wire logic        ev_serial_two_receive,  // serial 2 receive
   input  wire logic        ev_serial_two_transmit, // serial 2 transmit
   input  wire logic        ev_sync_port_two_coll,  // sync port 2 collision
   input  wire logic        ev_sync_port_two_event, // sync port 2 event
   output logic             periph_irq_ff,          // flags and enables request
   output logic             irq_ff                  // status and mask level
);
   logic [7:0]  ev_c;
   logic [7:0]  ev_d;
   logic [7:0]  flags_c;
   logic [7:0]  flags_d;
   logic [7:0]  enables_c;
   logic [7:0]  enables_d;
   logic        capture;
   logic        commit_wr;
   logic        lane0_wr;
   logic [7:0]  wbyte;
   logic        wr_flags_c;
   logic        wr_flags_d;
   logic        wr_enable_c;
   logic        wr_enable_d;
   logic        wr_status;
   logic        wr_mask;
   logic [1:0]  stat_ff;
   logic [1:0]  mask_ff;
   logic [1:0]  nxt_stat;
   logic [1:0]  nxt_mask;
   logic [31:0] nxt_readdata;
   logic [1:0]  nxt_response;
   logic        nxt_periph_irq;
   logic        nxt_irq;

   // R2 capture/compare positions
   // R3 timer match positions
   always_comb begin
      ev_c                   = 8'h00;
      ev_c[`PIF_BIT_CCP5]    = ev_capcomp_five;
      ev_c[`PIF_BIT_CCP4]    = ev_capcomp_four;
      ev_c[`PIF_BIT_CCP3]    = ev_capcomp_three;
      ev_c[`PIF_BIT_TIMER6]  = ev_sixth_timer_match;
      ev_c[`PIF_BIT_TIMER4]  = ev_fourth_timer_match;
   end

   // R5 serial port positions
   // R6 sync port positions
   always_comb begin
      ev_d                   = 8'h00;
      ev_d[`PIF_BIT_RX2]     = ev_serial_two_receive;
      ev_d[`PIF_BIT_TX2]     = ev_serial_two_transmit;
      ev_d[`PIF_BIT_BCOL2]   = ev_sync_port_two_coll;
      ev_d[`PIF_BIT_SYNC2]   = ev_sync_port_two_event;
   end

   pif_bus_front u_front (
      .mclk            (mclk),
      .srst            (srst),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_waitrequest (avs_waitrequest),
      .capture         (capture),
      .commit_wr       (commit_wr)
   );

   // only lane 0 carries register bits; other lanes are accepted and dropped
   assign lane0_wr    = commit_wr && avs_byteenable[0];
   assign wbyte       = avs_writedata[7:0];
   assign wr_flags_c  = lane0_wr && (avs_address == `PIF_OFS_FLAGS_C);
   assign wr_flags_d  = lane0_wr && (avs_address == `PIF_OFS_FLAGS_D);
   assign wr_enable_c = lane0_wr && (avs_address == `PIF_OFS_ENABLE_C);
   assign wr_enable_d = lane0_wr && (avs_address == `PIF_OFS_ENABLE_D);
   assign wr_status   = lane0_wr && (avs_address == `PIF_OFS_STATUS);
   assign wr_mask     = lane0_wr && (avs_address == `PIF_OFS_MASK);

   // R4 unimplemented bits masked
   // R9 software read/write flags
   pif_flag_bank #(
      .W    (8),
      .IMPL (`PIF_IMPL_C)
   ) u_bank_c (
      .mclk       (mclk),
      .srst       (srst),
      .event_in   (ev_c),
      .flag_wr    (wr_flags_c),
      .en_wr      (wr_enable_c),
      .wdata      (wbyte),
      .flags_ff   (flags_c),
      .enables_ff (enables_c)
   );

   // R5 unimplemented bits masked
   pif_flag_bank #(
      .W    (8),
      .IMPL (`PIF_IMPL_D)
   ) u_bank_d (
      .mclk       (mclk),
      .srst       (srst),
      .event_in   (ev_d),
      .flag_wr    (wr_flags_d),
      .en_wr      (wr_enable_d),
      .wdata      (wbyte),
      .flags_ff   (flags_d),
      .enables_ff (enables_d)
   );

   // status: one sticky bit per flag register, write one to clear;
   // an event in the clearing cycle keeps its bit set
   always_comb begin
      nxt_stat = stat_ff;
      nxt_mask = mask_ff;
      if (wr_status) begin
         nxt_stat = stat_ff & ~wbyte[1:0];
      end
      nxt_stat[`PIF_STAT_C] = nxt_stat[`PIF_STAT_C] | (|ev_c);
      nxt_stat[`PIF_STAT_D] = nxt_stat[`PIF_STAT_D] | (|ev_d);
      if (wr_mask) begin
         nxt_mask = wbyte[1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         stat_ff <= `PIF_RST_STAT;
         mask_ff <= `PIF_RST_STAT;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
      end
   end

   // read data is latched when the request is first seen and holds
   // through the acknowledge cycle, so a read never sees its own write
   always_comb begin
      nxt_readdata = avs_readdata;
      nxt_response = avs_response;
      if (capture) begin
         nxt_readdata = `PIF_RST_DATA;
         nxt_response = `PIF_RESP_OK;
         case (avs_address)
            // R1 pending flags readable
            `PIF_OFS_FLAGS_C:  nxt_readdata[7:0] = flags_c;
            `PIF_OFS_FLAGS_D:  nxt_readdata[7:0] = flags_d;
            `PIF_OFS_ENABLE_C: nxt_readdata[7:0] = enables_c;
            `PIF_OFS_ENABLE_D: nxt_readdata[7:0] = enables_d;
            `PIF_OFS_STATUS:   nxt_readdata[1:0] = stat_ff;
            `PIF_OFS_MASK:     nxt_readdata[1:0] = mask_ff;
            default:           nxt_response      = `PIF_RESP_DECERR;
         endcase
      end
   end

   always_comb begin
      // R10 enable gates flag
      // R11 or of gated flags
      nxt_periph_irq = |((flags_c & enables_c) | (flags_d & enables_d));
      nxt_irq        = |(stat_ff & mask_ff);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         avs_readdata  <= `PIF_RST_DATA;
         avs_response  <= `PIF_RESP_OK;
         periph_irq_ff <= 1'b0;
         irq_ff        <= 1'b0;
      end else begin
         avs_readdata  <= nxt_readdata;
         avs_response  <= nxt_response;
         periph_irq_ff <= nxt_periph_irq;
         irq_ff        <= nxt_irq;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   flag_hold_a: assert property ( // R1
      (ev_c == 8'h00) && !wr_flags_c |=> $stable(flags_c))
      else $error("flag register c changed without event or write");

   ccp_pos_a: assert property ( // R2
      ev_capcomp_five && ev_capcomp_four && ev_capcomp_three
      |=> flags_c[6] && flags_c[5] && flags_c[4])
      else $error("capture/compare flag not set at its bit");

   timer_pos_a: assert property ( // R3
      ev_sixth_timer_match && ev_fourth_timer_match
      |=> flags_c[3] && flags_c[1])
      else $error("timer match flag not set at its bit");

   unimpl_c_a: assert property ( // R4
      capture && avs_read && (avs_address == `PIF_OFS_FLAGS_C)
      |=> (avs_readdata[7] == 1'b0) && (avs_readdata[2] == 1'b0) && (avs_readdata[0] == 1'b0))
      else $error("unimplemented bit of flag register c read as one");

   serial_pos_a: assert property ( // R5
      ev_serial_two_receive && ev_serial_two_transmit
      |=> flags_d[5] && flags_d[4] && (flags_d[7:6] == 2'h0) && (flags_d[3:2] == 2'h0))
      else $error("serial flag placement wrong");

   sync_pos_a: assert property ( // R6
      ev_sync_port_two_coll && ev_sync_port_two_event |=> flags_d[1:0] == 2'h3)
      else $error("sync port flag placement wrong");

   set_indep_a: assert property ( // R7
      ev_capcomp_four && !enables_c[5] |=> flags_c[5])
      else $error("disabled event did not set its flag");

   sw_write_a: assert property ( // R9
      wr_flags_d && (ev_d == 8'h00) |=> flags_d == ($past(avs_writedata[7:0]) & `PIF_IMPL_D))
      else $error("software write to flag register d lost");

   reset_clear_a: assert property ( // R9
      disable iff (1'b0) srst |=> (flags_c == 8'h00) && (flags_d == 8'h00) && !periph_irq_ff)
      else $error("flags not cleared by reset");

   gate_block_a: assert property ( // R10
      (enables_c == 8'h00) && (enables_d == 8'h00) |=> !periph_irq_ff)
      else $error("request raised with all enables clear");

   req_or_a: assert property ( // R11
      ##1 periph_irq_ff == $past(|((flags_c & enables_c) | (flags_d & enables_d))))
      else $error("request output differs from gated flag or");

   bus_wait_a: assert property (
      capture |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");

   stat_keep_a: assert property (
      wr_status && wbyte[0] && (ev_c != 8'h00) |=> stat_ff[0])
      else $error("status set lost to a simultaneous clear");

   set_wins_a: assert property ( // R7
      wr_flags_c && ev_capcomp_five |=> flags_c[`PIF_BIT_CCP5])
      else $error("software clear beat a same-cycle event");

   clean_c_a: assert property ( // R4
      (flags_c & ~`PIF_IMPL_C) == 8'h00)
      else $error("unimplemented bit of flag register c set");

   unimpl_d_a: assert property ( // R5
      capture && avs_read && (avs_address == `PIF_OFS_FLAGS_D)
      |=> (avs_readdata[7:6] == 2'h0) && (avs_readdata[3:2] == 2'h0))
      else $error("unimplemented bit of flag register d read as one");

   sw_clear_a: assert property ( // R9
      wr_flags_c && (ev_c == 8'h00) |=> flags_c == ($past(wbyte) & `PIF_IMPL_C))
      else $error("software write to flag register c lost");

   rd_flags_a: assert property ( // R1
      capture && avs_read && (avs_address == `PIF_OFS_FLAGS_D) |=> avs_readdata[7:0] == $past(flags_d))
      else $error("flag register d read back differs from its flags");

   gate_pass_a: assert property ( // R10
      (|(flags_d & enables_d)) |=> periph_irq_ff)
      else $error("enabled pending flag raised no request");

   irq_level_a: assert property (
      ##1 irq_ff == $past(|(stat_ff & mask_ff)))
      else $error("interrupt output differs from masked status");

   stat_set_a: assert property (
      (ev_d != 8'h00) |=> stat_ff[`PIF_STAT_D])
      else $error("event of flag register d did not set its status bit");

   decode_err_a: assert property (
      capture && (avs_address[1:0] != 2'h0)
      |=> (avs_response == `PIF_RESP_DECERR) && (avs_readdata == `PIF_RST_DATA))
      else $error("unaligned address not refused");

   reset_regs_a: assert property ( // R9
      disable iff (1'b0) srst
      |=> (enables_c == 8'h00) && (enables_d == 8'h00) && (stat_ff == 2'h0)
          && (mask_ff == 2'h0) && avs_waitrequest)
      else $error("enables, status or handshake not cleared by reset");
endmodule

/* File: tb/pif_event_src.sv */
// event source model: drives one-cycle peripheral event pulses into the flag block
// assumes the bench steers fire and pat right after a rising edge
`timescale 1ns/1ps
module pif_event_src (
   input  wire logic       mclk, // system clock
   input  wire logic       srst, // sync reset, high
   input  wire logic       fire, // pulse request
   input  wire logic [8:0] pat,  // events to raise
   output logic      [8:0] ev    // event pulses, one cycle
);
   // events rise whatever the enables hold
   always_ff @(posedge mclk) begin
      if (srst) begin
         ev <= 9'h000;
      end else begin
         ev <= fire ? pat : 9'h000;
      end
   end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the peripheral flag block against a reference model
// assumes the register map of the defs header and one wait cycle per transfer
`timescale 1ns/1ps
`include "pif_defs.svh"
module tb_top;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic [1:0]  avs_response;
   logic        avs_waitrequest;
   logic        fire = 1'b0;
   logic [8:0]  pat = 9'h000;
   logic [8:0]  ev;
   logic        periph_irq_ff;
   logic        irq_ff;
   int          error_cnt = 0;
   int          num_checks = 0;
   logic [31:0] rnd = 32'h4B55_2731;
   logic [7:0]  mc = 8'h00, md = 8'h00, ec = 8'h00, ed = 8'h00;
   logic [1:0]  st = 2'h0, mk = 2'h0;
   logic [31:0] q;
   logic [1:0]  r;

   always #50 mclk = ~mclk;

   pif_event_src src (.mclk(mclk), .srst(srst), .fire(fire), .pat(pat), .ev(ev));

   pif_irq_regs dut (
      .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
      .ev_capcomp_five(ev[8]), .ev_capcomp_four(ev[7]), .ev_capcomp_three(ev[6]),
      .ev_sixth_timer_match(ev[5]), .ev_fourth_timer_match(ev[4]), .ev_serial_two_receive(ev[3]),
      .ev_serial_two_transmit(ev[2]), .ev_sync_port_two_coll(ev[1]), .ev_sync_port_two_event(ev[0]),
      .periph_irq_ff(periph_irq_ff), .irq_ff(irq_ff));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // request held until waitrequest is sampled low, released only after that edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      @(posedge mclk);
      avs_address    <= a;
      avs_writedata  <= {rnd[23:0], d};
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= ~wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         error_cnt++;
         $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
         close_out();
      end
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
      xfer(1'b1, a, d, be);
      rnd = lfsr(rnd);
      if (be[0]) begin
         case (a)
            `PIF_OFS_FLAGS_C:  mc = d & 8'h7A;
            `PIF_OFS_FLAGS_D:  md = d & 8'h33;
            `PIF_OFS_ENABLE_C: ec = d & 8'h7A;
            `PIF_OFS_ENABLE_D: ed = d & 8'h33;
            `PIF_OFS_STATUS:   st = st & ~d[1:0];
            `PIF_OFS_MASK:     mk = d[1:0];
            default: ;
         endcase
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      xfer(1'b0, a, 8'h00, 4'hF);
      chk("readdata", {24'h00_0000, e}, q);
      chk("response", {30'h0, er}, {30'h0, r});
   endtask

   task automatic rd_all;
      rd(`PIF_OFS_FLAGS_C, mc, 2'h0);
      rd(`PIF_OFS_FLAGS_D, md, 2'h0);
      rd(`PIF_OFS_ENABLE_C, ec, 2'h0);
      rd(`PIF_OFS_ENABLE_D, ed, 2'h0);
      rd(`PIF_OFS_STATUS, {6'h00, st}, 2'h0);
      rd(`PIF_OFS_MASK, {6'h00, mk}, 2'h0);
   endtask

   // both outputs are settled well within three edges of the last change
   task automatic irq_chk;
      repeat (3) @(posedge mclk);
      chk("periph_irq_ff", {31'h0, |((mc & ec) | (md & ed))}, {31'h0, periph_irq_ff});
      chk("irq_ff", {31'h0, |(st & mk)}, {31'h0, irq_ff});
   endtask

   task automatic fire_ev(input logic [8:0] p);
      @(posedge mclk);
      fire <= 1'b1;
      pat  <= p;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (2) @(posedge mclk);
      mc = mc | {1'b0, p[8:5], 1'b0, p[4], 1'b0};
      md = md | {2'b00, p[3:2], 2'b00, p[1:0]};
      st = st | {|p[3:0], |p[8:4]};
   endtask

   task automatic clr_flags;
      wr(`PIF_OFS_FLAGS_C, 8'h00);
      wr(`PIF_OFS_FLAGS_D, 8'h00);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      rd_all();
      rd(8'h18, 8'h00, 2'h3);
      rd(8'h01, 8'h00, 2'h3);
      irq_chk();
      wr(`PIF_OFS_FLAGS_C, 8'hFF);
      wr(`PIF_OFS_FLAGS_D, 8'hFF);
      wr(`PIF_OFS_ENABLE_C, 8'hFF);
      wr(`PIF_OFS_ENABLE_D, 8'hFF);
      wr(8'h18, 8'hFF);
      wr(`PIF_OFS_FLAGS_C, 8'h00, 4'hE);
      rd_all();
      irq_chk();
      clr_flags();
      irq_chk();
      wr(`PIF_OFS_ENABLE_C, 8'h00);
      wr(`PIF_OFS_ENABLE_D, 8'h00);
      // walk each event alone with enables and mask off
      for (int i = 0; i < 9; i++) begin
         fire_ev(9'h001 << i);
         rd_all();
         irq_chk();
         clr_flags();
         wr(`PIF_OFS_STATUS, 8'h03);
      end
      for (int i = 0; i < 12; i++) begin
         clr_flags();
         wr(`PIF_OFS_ENABLE_C, rnd[7:0]);
         wr(`PIF_OFS_ENABLE_D, rnd[15:8]);
         wr(`PIF_OFS_MASK, {6'h00, rnd[31:30]});
         fire_ev(rnd[24:16]);
         irq_chk();
         rd_all();
         wr(`PIF_OFS_STATUS, {6'h00, rnd[29:28]});
         irq_chk();
      end
      // events land in the very cycle a clear commits: the set must win
      fork
         wr(`PIF_OFS_FLAGS_C, 8'h00);
         fire_ev(9'h1FF);
      join
      rd_all();
      fork
         wr(`PIF_OFS_STATUS, 8'h03);
         fire_ev(9'h1FF);
      join
      rd_all();
      irq_chk();
      // reset in mid-run with every flag and status bit set
      fire_ev(9'h1FF);
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      mc = 8'h00;
      md = 8'h00;
      ec = 8'h00;
      ed = 8'h00;
      st = 2'h0;
      mk = 2'h0;
      rd_all();
      irq_chk();
      close_out();
   end
endmodule
